//--- core/hprc_pkg.sv
/*
  shared constants and types of the hibernation power and rtc controller.
  assumes nothing beyond a systemverilog compiler; included by every design file except the synchroniser.
*/
package hprc_pkg;

  localparam int HPRC_DATA_W = 32;
  localparam int HPRC_MEM_WORDS = 64;
  localparam int HPRC_XTAL_DIV = 128;
  localparam int HPRC_TRIM_PERIOD = 64;
  localparam int HPRC_TRIM_W = 16;

  localparam logic [31:0] HPRC_COUNT_RST = 32'h0000_0000;
  localparam logic [31:0] HPRC_MATCH_RST = 32'hFFFF_FFFF;
  localparam logic [31:0] HPRC_LOAD_RST = 32'hFFFF_FFFF;
  localparam logic [15:0] HPRC_TRIM_NOMINAL = 16'h7FFF;
  localparam logic [3:0] HPRC_MASK_RST = 4'h0;

  // event bit positions in raw, mask, masked and clear views
  localparam int HPRC_EV_MATCH0 = 0;
  localparam int HPRC_EV_MATCH1 = 1;
  localparam int HPRC_EV_LOW_BATTERY_FLAG = 2;
  localparam int HPRC_EV_WAKE = 3;
  localparam int HPRC_EV_W = 4;

  typedef struct packed {
    logic osc_enable;
    logic osc_source_select;
    logic low_battery_detect_enable;
    logic abort_on_low_battery;
    logic rtc_count_enable;
    logic pin_wake_enable;
    logic match_wake_enable;
  } hprc_ctl_t;

  localparam hprc_ctl_t HPRC_CTL_RST = '0;

  typedef struct packed {
    logic wr;
    logic [5:0] addr;
    logic [31:0] wdata;
  } hprc_mem_req_t;

  typedef enum logic [1:0] {
    HPRC_AWAKE,
    HPRC_HIBERNATE,
    HPRC_WAKING
  } hprc_state_t;

endpackage

//--- core/hprc_retmem.sv
/*
  retained word memory with registered read data.
  assumes one write or read address per cycle from the controller clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module hprc_retmem
  import hprc_pkg::*;
#(
  parameter int DEPTH = HPRC_MEM_WORDS
) (
  // clock
  input wire logic ref_clk,
  input wire logic clk_en,
  // access
  input wire hprc_mem_req_t req,
  output logic [31:0] rdata
);
  logic [31:0] mem [DEPTH];
  wire logic [5:0] word_addr = req.addr;

  // contents survive every reset, like battery-backed cells
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (req.wr) begin
        mem[word_addr] <= req.wdata;
      end
      rdata <= mem[word_addr];
    end
  end
endmodule
`default_nettype wire

//--- core/hprc_sync.sv
/*
  two-flop synchroniser for pin level inputs.
  assumes the input is asynchronous to ref_clk; only the second flop is read.
*/
`timescale 1ns/1ps
`default_nettype none
module hprc_sync #(
  parameter int W = 1
) (
  // clock
  input wire logic ref_clk,
  input wire logic clk_en,
  // data
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

//--- core/hprc_top.sv
/*
  hibernation power and rtc controller: regulator enable, wake logic, seconds counter
  with trimmed predivider, two match comparators, retained memory and event flags.
  assumes register strobes come from logic on ref_clk; pins and the rtc oscillator
  input are asynchronous and are synchronised here before use.
*/
// Summary of operation
// - on entering hibernation drive active-low regulator enable to remove power
// - while hibernating, wake on armed pin or armed rtc match
// - on wake release the regulator-off output so supply returns
// - crystal path divides its input by 128 to get the timebase
// - osc enable starts the source; select 0 crystal, 1 direct input
// - with detection on, a low battery sets the low-battery flag
// - with abort also set, low battery refuses hibernation entry
// - battery level is not evaluated while hibernated
// - 32-bit seconds counter driven by a predivider counting timebase ticks
// - trim value divides one second in 64; others use nominal division
// - trim above nominal slows the clock, below speeds it up
// - two match registers; a match always flags its event and also wakes when armed and hibernating
// - counter runs only when enabled; a load write replaces it anytime
// - counter keeps running while enabled and battery valid, hibernating or not
// - 64 retained 32-bit words, readable and writable, kept across hibernation
// - sleep request starts hibernation; a wake source must be armed first
// - pin wake and match wake enables arm their sources independently
// - events for wake pin, match and low battery, ORed into one interrupt
// - raw view shows all pending events; masked view shows enabled ones
// - writing one to a clear bit clears that pending event
// - registers reset by system reset only with both enables clear, or cold reset
`timescale 1ns/1ps
`default_nettype none
module hprc_top
  import hprc_pkg::*;
#(
  parameter int MEM_DEPTH = HPRC_MEM_WORDS,
  parameter int XTAL_DIV = HPRC_XTAL_DIV,
  parameter int TRIM_PERIOD = HPRC_TRIM_PERIOD
) (
  // clock, resets and freeze
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sys_reset,
  input wire logic clk_en,
  // control register
  input wire logic ctl_wr,
  input wire hprc_ctl_t ctl_wdata,
  input wire logic sleep_request,
  output hprc_ctl_t ctl_status,
  // rtc registers
  input wire logic load_wr,
  input wire logic match0_wr,
  input wire logic match1_wr,
  input wire logic trim_wr,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] rtc_count_reg,
  output logic [31:0] rtc_match0_reg,
  output logic [31:0] rtc_match1_reg,
  output logic [31:0] rtc_load_reg,
  output logic [15:0] rtc_trim_reg,
  // retained memory
  input wire hprc_mem_req_t mem_req,
  output logic [31:0] mem_rdata,
  // events
  input wire logic mask_wr,
  input wire logic [HPRC_EV_W-1:0] mask_wdata,
  input wire logic event_clear_wr,
  input wire logic [HPRC_EV_W-1:0] event_clear,
  output logic [HPRC_EV_W-1:0] event_mask,
  output logic [HPRC_EV_W-1:0] raw_event_status,
  output logic [HPRC_EV_W-1:0] masked_event_status,
  output logic irq,
  // pins and analog indications
  input wire logic osc_in,
  input wire logic wake_n,
  input wire logic low_battery_in,
  input wire logic vbat_valid,
  output logic regulator_off_n,
  output logic regulator_off_n_oe,
  output logic hibernating
);

  generate
    if (MEM_DEPTH != 64) begin : g_bad_depth
      $error("MEM_DEPTH must be 64 to match the 6-bit word address");
    end
    if (XTAL_DIV < 2 || XTAL_DIV > 128) begin : g_bad_div
      $error("XTAL_DIV must lie in 2..128");
    end
    if (TRIM_PERIOD < 2 || TRIM_PERIOD > 64) begin : g_bad_trim
      $error("TRIM_PERIOD must lie in 2..64");
    end
  endgenerate

  localparam logic [6:0] XTAL_LAST = 7'(XTAL_DIV - 1);
  localparam logic [5:0] TRIM_LAST = 6'(TRIM_PERIOD - 1);

  function automatic logic [HPRC_EV_W-1:0] ev_update(
    input logic [HPRC_EV_W-1:0] cur,
    input logic [HPRC_EV_W-1:0] set,
    input logic [HPRC_EV_W-1:0] clr
  );
    // a set in the clearing cycle wins
    ev_update = (cur & ~clr) | set;
  endfunction

  // pin synchronisers
  logic [3:0] pins_s;

  hprc_sync #(
    .W(4)
  ) u_sync (
    .ref_clk(ref_clk),
    .clk_en(clk_en),
    .async_in({osc_in, wake_n, low_battery_in, vbat_valid}),
    .sync_out(pins_s)
  );

  wire logic osc_s = pins_s[3];
  wire logic wake_n_s = pins_s[2];
  wire logic low_battery_flag_s = pins_s[1];
  wire logic vbat_s = pins_s[0];

  // state
  hprc_state_t state_r, state_nxt;
  hprc_ctl_t ctl_r;
  logic osc_prev_r;
  logic wake_prev_r;
  logic [6:0] xtal_cnt_r;
  logic [15:0] prediv_r;
  logic [5:0] sec_idx_r;
  logic [31:0] count_r;
  logic [31:0] match0_r;
  logic [31:0] match1_r;
  logic [31:0] load_r;
  logic [15:0] trim_r;
  logic [HPRC_EV_W-1:0] raw_r;
  logic [HPRC_EV_W-1:0] mask_r;
  logic eq0_prev_r;
  logic eq1_prev_r;
  logic reg_off_n_r;

  // module registers ignore a system reset while the rtc counter is enabled or pin wake is armed
  wire logic mod_rst = reset | (sys_reset & ~ctl_r.rtc_count_enable & ~ctl_r.pin_wake_enable);

  // timebase: one tick per 32.768 kHz period
  wire logic osc_edge = ctl_r.osc_enable & osc_s & ~osc_prev_r;
  wire logic xtal_wrap = (xtal_cnt_r == XTAL_LAST);
  wire logic tick = ctl_r.osc_source_select ? osc_edge : (osc_edge & xtal_wrap);

  // predivider counts down from nominal; the first second of every period is trimmed
  wire logic trim_second = (sec_idx_r == 6'h00);
  wire logic [15:0] div_reload = trim_second ? trim_r : HPRC_TRIM_NOMINAL;
  wire logic prediv_done = (prediv_r == 16'(HPRC_TRIM_NOMINAL - div_reload));
  wire logic sec_tick = tick & prediv_done;
  wire logic counting = ctl_r.rtc_count_enable & vbat_s;

  // match comparators, one event on each new equality
  wire logic eq0 = (count_r == match0_r);
  wire logic eq1 = (count_r == match1_r);
  wire logic hit0 = eq0 & ~eq0_prev_r;
  wire logic hit1 = eq1 & ~eq1_prev_r;

  // wake pin is active low; an edge raises the event, the level wakes
  wire logic wake_asserted = ~wake_n_s;
  wire logic wake_edge = wake_asserted & wake_prev_r;

  // battery is measured only while awake
  wire logic awake = (state_r != HPRC_HIBERNATE);
  wire logic low_battery_flag_now = ctl_r.low_battery_detect_enable & awake & low_battery_flag_s;
  wire logic low_battery_flag_seen = raw_r[HPRC_EV_LOW_BATTERY_FLAG] | low_battery_flag_now;

  wire logic [HPRC_EV_W-1:0] ev_set = {wake_edge, low_battery_flag_now, hit1, hit0};
  wire logic [HPRC_EV_W-1:0] ev_clr = event_clear_wr ? event_clear : '0;

  // entry needs an armed wake source and no abort on a low battery
  wire logic wake_armed = ctl_r.pin_wake_enable | ctl_r.match_wake_enable;
  wire logic abort_entry = ctl_r.abort_on_low_battery & low_battery_flag_seen;
  wire logic enter_ok = sleep_request & wake_armed & ~abort_entry;

  wire logic pin_wake = ctl_r.pin_wake_enable & wake_asserted;
  wire logic match_wake = ctl_r.match_wake_enable & (hit0 | hit1);
  wire logic wake_event = pin_wake | match_wake;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      HPRC_AWAKE: begin
        if (enter_ok) begin
          state_nxt = HPRC_HIBERNATE;
        end
      end
      HPRC_HIBERNATE: begin
        if (wake_event) begin
          state_nxt = HPRC_WAKING;
        end
      end
      HPRC_WAKING: begin
        state_nxt = HPRC_AWAKE;
      end
      default: begin
        state_nxt = HPRC_AWAKE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (mod_rst) begin
        state_r <= HPRC_AWAKE;
        reg_off_n_r <= 1'b1;
      end else begin
        state_r <= state_nxt;
        reg_off_n_r <= (state_nxt != HPRC_HIBERNATE);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (mod_rst) begin
        ctl_r <= HPRC_CTL_RST;
        mask_r <= HPRC_MASK_RST;
      end else begin
        if (ctl_wr) begin
          ctl_r <= ctl_wdata;
        end
        if (mask_wr) begin
          mask_r <= mask_wdata;
        end
      end
    end
  end

  // the crystal divider free-runs on input edges
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (mod_rst) begin
        osc_prev_r <= 1'b0;
        xtal_cnt_r <= 7'h00;
      end else begin
        osc_prev_r <= osc_s;
        if (osc_edge) begin
          xtal_cnt_r <= xtal_wrap ? 7'h00 : xtal_cnt_r + 7'h01;
        end
      end
    end
  end

  // a second ends after N+1 ticks for divide value N; a trim write mid-second may overshoot
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (mod_rst) begin
        prediv_r <= HPRC_TRIM_NOMINAL;
        sec_idx_r <= 6'h00;
      end else if (counting && tick) begin
        if (prediv_done) begin
          prediv_r <= HPRC_TRIM_NOMINAL;
          sec_idx_r <= (sec_idx_r == TRIM_LAST) ? 6'h00 : sec_idx_r + 6'h01;
        end else begin
          prediv_r <= prediv_r - 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (mod_rst) begin
        count_r <= HPRC_COUNT_RST;
      end else if (load_wr) begin
        count_r <= reg_wdata;
      end else if (counting && sec_tick) begin
        count_r <= count_r + 32'h0000_0001;
      end
    end
  end

  // writes are assumed spaced by software, so no write collision logic here
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (mod_rst) begin
        match0_r <= HPRC_MATCH_RST;
        match1_r <= HPRC_MATCH_RST;
        load_r <= HPRC_LOAD_RST;
        trim_r <= HPRC_TRIM_NOMINAL;
      end else begin
        if (match0_wr) begin
          match0_r <= reg_wdata;
        end
        if (match1_wr) begin
          match1_r <= reg_wdata;
        end
        if (load_wr) begin
          load_r <= reg_wdata;
        end
        if (trim_wr) begin
          trim_r <= reg_wdata[15:0];
        end
      end
    end
  end

  // equality history starts set so reset values never raise a false match
  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (mod_rst) begin
        eq0_prev_r <= 1'b1;
        eq1_prev_r <= 1'b1;
        wake_prev_r <= 1'b0;
      end else begin
        eq0_prev_r <= eq0;
        eq1_prev_r <= eq1;
        wake_prev_r <= wake_n_s;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (mod_rst) begin
        raw_r <= '0;
      end else begin
        raw_r <= ev_update(raw_r, ev_set, ev_clr);
      end
    end
  end

  wire logic [HPRC_EV_W-1:0] masked = raw_r & mask_r;

  always_ff @(posedge ref_clk) begin
    if (clk_en) begin
      if (mod_rst) begin
        masked_event_status <= '0;
        irq <= 1'b0;
      end else begin
        masked_event_status <= ev_update(raw_r, ev_set, ev_clr) & mask_r;
        irq <= |(ev_update(raw_r, ev_set, ev_clr) & mask_r);
      end
    end
  end

  hprc_retmem #(
    .DEPTH(MEM_DEPTH)
  ) u_retmem (
    .ref_clk(ref_clk),
    .clk_en(clk_en),
    .req(mem_req),
    .rdata(mem_rdata)
  );

  assign ctl_status = ctl_r;
  assign rtc_count_reg = count_r;
  assign rtc_match0_reg = match0_r;
  assign rtc_match1_reg = match1_r;
  assign rtc_load_reg = load_r;
  assign rtc_trim_reg = trim_r;
  assign event_mask = mask_r;
  assign raw_event_status = raw_r;
  assign regulator_off_n = reg_off_n_r;
  // open drain: only ever pulls low
  assign regulator_off_n_oe = ~reg_off_n_r;
  assign hibernating = ~reg_off_n_r;

  wire logic unused_ok = ^masked;

endmodule
`default_nettype wire

//--- tb/hprc_checker.sv
/*
  concurrent checks on the controller ports.
  assumes binding to hprc_top; one clock domain with cold reset as disable.
*/
`timescale 1ns/1ps
`default_nettype none
module hprc_checker
  import hprc_pkg::*;
(
  // clock and resets
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic sys_reset,
  input wire logic clk_en,
  // requests
  input wire logic sleep_request,
  input wire logic load_wr,
  input wire logic mask_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic wake_n,
  // state
  input wire hprc_ctl_t ctl_status,
  input wire logic [31:0] rtc_count_reg,
  input wire logic [31:0] rtc_load_reg,
  input wire logic [HPRC_EV_W-1:0] event_mask,
  input wire logic [HPRC_EV_W-1:0] raw_event_status,
  input wire logic [HPRC_EV_W-1:0] masked_event_status,
  input wire logic irq,
  input wire logic regulator_off_n,
  input wire logic regulator_off_n_oe,
  input wire logic hibernating
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // settled awake for two cycles so the waking step is excluded
  sequence take_sleep;
    sleep_request && clk_en && regulator_off_n && $past(regulator_off_n) && $past(regulator_off_n, 2)
    && (ctl_status.pin_wake_enable || ctl_status.match_wake_enable) && !ctl_status.abort_on_low_battery;
  endsequence
  sequence pin_held;
    (!regulator_off_n && ctl_status.pin_wake_enable && clk_en && !wake_n) [*3];
  endsequence
  chk_oe_tracks: assert property (regulator_off_n_oe == !regulator_off_n)
    else $error("open-drain enable disagrees with regulator output");
  chk_sleep_taken: assert property (take_sleep |=> !regulator_off_n && hibernating)
    else $error("sleep request not taken");
  chk_abort_low_battery_flag: assert property (sleep_request && regulator_off_n && ctl_status.abort_on_low_battery
    && raw_event_status[HPRC_EV_LOW_BATTERY_FLAG] |=> regulator_off_n)
    else $error("hibernation entered despite low battery abort");
  chk_no_source: assert property (sleep_request && regulator_off_n && !ctl_status.pin_wake_enable
    && !ctl_status.match_wake_enable |=> regulator_off_n)
    else $error("hibernation entered with no wake source");
  chk_pin_wake: assert property (pin_held |-> ##[0:3] regulator_off_n)
    else $error("armed wake pin did not restore power");
  chk_low_battery_flag_held: assert property (hibernating && $past(hibernating)
    |-> !$rose(raw_event_status[HPRC_EV_LOW_BATTERY_FLAG]))
    else $error("battery evaluated while hibernating");
  chk_masked_view: assert property (!$past(mask_wr) |-> masked_event_status == (raw_event_status & event_mask))
    else $error("masked status is not raw and mask");
  chk_irq_or: assert property (irq == (|masked_event_status))
    else $error("interrupt is not the or of masked events");
  chk_load_count: assert property (load_wr && clk_en |=> rtc_count_reg == $past(reg_wdata)
    && rtc_load_reg == $past(reg_wdata))
    else $error("load write did not replace counter");
  chk_count_idle: assert property (!ctl_status.rtc_count_enable && !load_wr && !sys_reset
    |=> $stable(rtc_count_reg))
    else $error("counter moved while disabled");
  chk_count_step: assert property (rtc_count_reg != $past(rtc_count_reg) && !$past(load_wr)
    && !$past(sys_reset) && !$past(reset) |-> rtc_count_reg == $past(rtc_count_reg) + 32'h0000_0001)
    else $error("counter advanced by other than one");
endmodule
bind hprc_top hprc_checker chk_i (.ref_clk, .reset, .sys_reset, .clk_en, .sleep_request, .load_wr, .mask_wr,
  .reg_wdata, .wake_n, .ctl_status, .rtc_count_reg, .rtc_load_reg, .event_mask, .raw_event_status,
  .masked_event_status, .irq, .regulator_off_n, .regulator_off_n_oe, .hibernating);
`default_nettype wire

//--- tb/hprc_partner.sv
/*
  far side of the controller: regulator behind the open-drain enable, wake source, rtc oscillator.
  assumes the bench commands the wake source and oscillator run; pin pull-ups are modelled here.
*/
`timescale 1ns/1ps
`default_nettype none
module hprc_partner (
  // regulator side
  input wire logic regulator_off_n,
  input wire logic regulator_off_n_oe,
  output logic supply_on,
  // wake source
  input wire logic wake_cmd,
  output logic wake_n,
  // oscillator
  input wire logic osc_run,
  output logic osc_in
);
  logic hib_pin;
  // only a driven enable pulls the line low; otherwise the pull-up wins
  assign hib_pin = (regulator_off_n_oe && !regulator_off_n) ? 1'b0 : 1'b1;
  initial supply_on = 1'b1;
  // supply follows the line after a settling delay
  always @(hib_pin) supply_on <= #150 hib_pin;
  // weak pull-up keeps the wake pin high when the source is idle
  assign wake_n = !wake_cmd;
  initial osc_in = 1'b0;
  // free running while on, stands low when off
  always begin
    #47;
    osc_in = osc_run ? !osc_in : 1'b0;
  end
endmodule
`default_nettype wire

//--- tb/hprc_top_test.sv
/*
  self-checking bench for the controller: strobe tasks, reset values, events, sleep and wake, rtc rate.
  assumes the partner model on the regulator, wake and oscillator pins; divider and trim period shortened.
*/
`timescale 1ns/1ps
`default_nettype none
module hprc_top_test
  import hprc_pkg::*;
;
  logic ref_clk, reset, sys_reset, clk_en, ctl_wr, sleep_request, load_wr, match0_wr, match1_wr, trim_wr;
  logic mask_wr, event_clear_wr, irq, osc_in, wake_n, low_battery_in, vbat_valid, wake_cmd, supply_on;
  logic regulator_off_n, regulator_off_n_oe, hibernating;
  hprc_ctl_t ctl_wdata, ctl_status;
  hprc_mem_req_t mem_req;
  logic [31:0] reg_wdata, rtc_count_reg, rtc_match0_reg, rtc_match1_reg, rtc_load_reg, mem_rdata;
  logic [15:0] rtc_trim_reg;
  logic [3:0] mask_wdata, event_clear, event_mask, raw_event_status, masked_event_status;
  int err_total, checks, n, e;
  hprc_top #(.XTAL_DIV(4), .TRIM_PERIOD(4)) dut (.ref_clk, .reset, .sys_reset, .clk_en, .ctl_wr, .ctl_wdata,
    .sleep_request, .ctl_status, .load_wr, .match0_wr, .match1_wr, .trim_wr, .reg_wdata, .rtc_count_reg,
    .rtc_match0_reg, .rtc_match1_reg, .rtc_load_reg, .rtc_trim_reg, .mem_req, .mem_rdata, .mask_wr,
    .mask_wdata, .event_clear_wr, .event_clear, .event_mask, .raw_event_status, .masked_event_status, .irq,
    .osc_in, .wake_n, .low_battery_in, .vbat_valid, .regulator_off_n, .regulator_off_n_oe, .hibernating);
  hprc_partner far_i (.regulator_off_n, .regulator_off_n_oe, .supply_on, .wake_cmd, .wake_n,
    .osc_run(1'b1), .osc_in);
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = !ref_clk;
  end
  task chk(input string nm, input logic [191:0] s, input logic [191:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task results;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one strobe per call; the idle cycle between calls keeps writes spaced
  task act(input int k, input logic [31:0] d);
    @(negedge ref_clk);
    reg_wdata = d;
    ctl_wdata = d[6:0];
    mask_wdata = d[3:0];
    event_clear = d[3:0];
    {sleep_request, event_clear_wr, mask_wr, trim_wr, match1_wr, match0_wr, load_wr, ctl_wr} = 8'h01 << k;
    @(negedge ref_clk);
    {sleep_request, event_clear_wr, mask_wr, trim_wr, match1_wr, match0_wr, load_wr, ctl_wr} = 8'h00;
  endtask
  task mem(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(negedge ref_clk);
    mem_req = '{w, a, d};
    @(negedge ref_clk);
    mem_req.wr = 1'b0;
  endtask
  task rst;
    @(negedge ref_clk);
    reset = 1'b1;
    repeat (8) @(negedge ref_clk);
    reset = 1'b0;
  endtask
  // trimmed first second of four ticks, counted in oscillator edges; 40 means it never came
  task rate(input logic [6:0] c, input logic v, input int ex);
    rst();
    vbat_valid = v;
    act(4, 32'h0000_0003);
    act(0, {25'h0, c});
    for (e = 0; e < 40 && rtc_count_reg === 32'h0000_0000; e++) @(posedge osc_in);
    chk("rate", e >= ex && e <= ex + 2, 1'b1);
    @(negedge ref_clk);
    vbat_valid = 1'b1;
  endtask
  initial begin
    {reset, clk_en, vbat_valid} = 3'b111;
    {sys_reset, wake_cmd, low_battery_in, ctl_wdata, reg_wdata, mask_wdata, event_clear} = '0;
    {sleep_request, event_clear_wr, mask_wr, trim_wr, match1_wr, match0_wr, load_wr, ctl_wr} = 8'h00;
    mem_req = '0;
    rst();
    chk("rst", {rtc_count_reg, rtc_match0_reg, rtc_match1_reg, rtc_load_reg, rtc_trim_reg, ctl_status, event_mask,
      raw_event_status, regulator_off_n, regulator_off_n_oe, irq}, {HPRC_COUNT_RST, HPRC_MATCH_RST,
      HPRC_MATCH_RST, HPRC_LOAD_RST, HPRC_TRIM_NOMINAL, HPRC_CTL_RST, HPRC_MASK_RST, 7'b0000_100});
    mem(1'b1, 6'h00, 32'hA5A5_0001);
    mem(1'b1, 6'h3F, 32'h5A5A_003F);
    act(5, 32'h0000_000F);
    act(2, 32'h0000_0020);
    act(3, 32'h0000_0021);
    act(1, 32'h0000_0020);
    act(1, 32'h0000_0021);
    repeat (3) @(negedge ref_clk);
    chk("match", {raw_event_status, masked_event_status, irq}, 9'h067);
    chk("regs", {rtc_match0_reg, rtc_match1_reg, rtc_load_reg}, {32'h0000_0020, 32'h0000_0021, 32'h0000_0021});
    act(6, 32'h0000_0001);
    repeat (3) @(negedge ref_clk);
    chk("clear", raw_event_status, 4'h2);
    act(5, 32'h0000_0000);
    act(1, 32'h0000_0020);
    repeat (3) @(negedge ref_clk);
    chk("masked", {raw_event_status, masked_event_status, irq}, 9'h060);
    act(6, 32'h0000_000F);
    act(0, 32'h0000_001A);
    low_battery_in = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("low_battery_flag", raw_event_status[HPRC_EV_LOW_BATTERY_FLAG], 1'b1);
    act(7, 32'h0000_0000);
    chk("abort", regulator_off_n, 1'b1);
    act(0, 32'h0000_0010);
    act(7, 32'h0000_0000);
    chk("nosrc", regulator_off_n, 1'b1);
    act(0, 32'h0000_0012);
    act(7, 32'h0000_0000);
    act(6, 32'h0000_0004);
    repeat (10) @(negedge ref_clk);
    chk("sleep", {regulator_off_n, regulator_off_n_oe, hibernating, raw_event_status[2], supply_on}, 5'h0C);
    low_battery_in = 1'b0;
    wake_cmd = 1'b1;
    for (n = 0; n < 20 && regulator_off_n !== 1'b1; n++) @(negedge ref_clk);
    repeat (10) @(negedge ref_clk);
    chk("wake", {regulator_off_n, supply_on, raw_event_status[HPRC_EV_WAKE]}, 3'b111);
    wake_cmd = 1'b0;
    mem(1'b0, 6'h00, 32'h0000_0000);
    chk("mem0", mem_rdata, 32'hA5A5_0001);
    mem(1'b0, 6'h3F, 32'h0000_0000);
    chk("mem63", mem_rdata, 32'h5A5A_003F);
    // crystal model settles at once, so no wait after enabling it
    rate(7'h44, 1'b1, 16);
    rate(7'h24, 1'b1, 40);
    rate(7'h64, 1'b0, 40);
    rate(7'h64, 1'b1, 4);
    repeat (40) @(posedge osc_in);
    chk("nominal", {rtc_trim_reg, rtc_count_reg}, {16'h0003, 32'h0000_0001});
    rst();
    act(4, 32'h0000_0003);
    act(2, 32'h0000_0001);
    act(0, 32'h0000_0065);
    act(7, 32'h0000_0000);
    wake_cmd = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("pinoff", regulator_off_n, 1'b0);
    wake_cmd = 1'b0;
    for (n = 0; n < 60 && regulator_off_n !== 1'b1; n++) @(negedge ref_clk);
    chk("mwake", {regulator_off_n, rtc_count_reg}, {1'b1, 32'h0000_0001});
    sys_reset = 1'b1;
    @(negedge ref_clk);
    sys_reset = 1'b0;
    chk("sysign", ctl_status, 7'h65);
    act(0, 32'h0000_0040);
    sys_reset = 1'b1;
    @(negedge ref_clk);
    sys_reset = 1'b0;
    @(negedge ref_clk);
    chk("sysrst", ctl_status, 7'h00);
    results();
  end
  // whole run is well under this span
  initial begin
    #400000;
    err_total++;
    results();
  end
endmodule
`default_nettype wire
